// file: inc/fct_pkg.sv
// Constants shared by the five-channel timer control block.
// Assumes a 32-bit AXI4-Lite register bus, one aligned word per register.
package fct_pkg;
	// ==========================================================
	// Bus geometry, channel count and counter width
	localparam int ADDR_W = 12;
	localparam int DATA_W = 32;
	localparam int NCH = 5;
	localparam int CNT_W = 16;
	// ==========================================================
	// Register indices, byte address is four times the index
	localparam logic [7:0] IDX_RUN = 8'h60;
	localparam logic [7:0] IDX_SYNC = 8'h61;
	localparam logic [7:0] IDX_MODE = 8'h62;
	localparam logic [7:0] IDX_PAIR = 8'h63;
	localparam logic [7:0] IDX_CLK0 = 8'h64;
	localparam logic [7:0] IDX_GRA0 = 8'h68;
	localparam logic [7:0] IDX_GRB0 = 8'h69;
	localparam logic [7:0] IDX_STAT = 8'h6A;
	localparam logic [7:0] IDX_MASK = 8'h6B;
	localparam logic [7:0] IDX_CNT0 = 8'h6C;
	localparam logic [7:0] IDX_CH4_GENERAL_REG_B = 8'h6D;
	localparam logic [7:0] IDX_CH4_BUFFER_REG_B = 8'h6E;
	// ==========================================================
	// Reset values and writable masks, reserved bits read as one
	localparam logic [7:0] RST_RUN = 8'hE0;
	localparam logic [7:0] RST_SYNC = 8'hE0;
	localparam logic [7:0] RST_MODE = 8'h80;
	localparam logic [7:0] RST_PAIR = 8'hC7;
	localparam logic [7:0] RST_CLK0 = 8'h80;
	localparam logic [7:0] WM_RUN = 8'h1F;
	localparam logic [7:0] WM_MODE = 8'h7F;
	localparam logic [7:0] WM_PAIR = 8'h38;
	localparam logic [7:0] WM_CLK0 = 8'h7F;
	localparam logic [15:0] RST_GR = 16'hFFFF;
	// ==========================================================
	// Field positions
	localparam int MODE_PHASE_BIT = 6;
	localparam int MODE_FLAG_DIRECTION_BIT_BIT = 5;
	localparam int PAIR_LSB = 4;
	localparam int PAIR_BUF_BIT = 3;
	localparam int CLR_LSB = 5;
	localparam int EDGE_LSB = 3;
	localparam int PSC_LSB = 0;
	// Status and mask layout
	localparam int ST_W = 4;
	localparam int ST_CMA = 0;
	localparam int ST_CMB = 1;
	localparam int ST_OVF0 = 2;
	localparam int ST_OVF2 = 3;
	// ==========================================================
	// Codes
	localparam logic [1:0] CLR_NONE = 2'h0;
	localparam logic [1:0] CLR_GRA = 2'h1;
	localparam logic [1:0] CLR_GRB = 2'h2;
	localparam logic [1:0] CLR_SYNC = 2'h3;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		PAIR_NORMAL,
		PAIR_COMPL,
		PAIR_RESYNC
	} fct_pair_t;

	// ==========================================================
	// Pair combination decode
	function automatic fct_pair_t pair_decode(input logic [1:0] code);
		case (code)
			2'h2: pair_decode = PAIR_COMPL;
			2'h3: pair_decode = PAIR_RESYNC;
			default: pair_decode = PAIR_NORMAL;
		endcase
	endfunction : pair_decode
endpackage : fct_pkg

// file: src/fct_prescaler.sv
// Counter clock selection: internal divide or external pin edges.
// Assumes external clock pins are asynchronous to i_mclk.
`timescale 1ns/10ps
`default_nettype none
module fct_prescaler (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// External clock pins, a to d
	input wire logic [3:0] i_ext_clk,
	// Selection
	input wire logic [2:0] i_prescale,
	input wire logic [1:0] i_edge,
	// Counter clock tick
	output logic o_tick
);
	logic [3:0] sync1_r;
	logic [3:0] sync2_r;
	logic [3:0] prev_r;
	logic [2:0] div_r;
	logic [2:0] mask;
	logic cur;
	logic old;
	logic ext_tick;

	// ==========================================================
	// Two-flop synchroniser, then edge history
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			sync1_r <= 4'h0;
			sync2_r <= 4'h0;
			prev_r <= 4'h0;
		end else begin
			sync1_r <= i_ext_clk;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	// Free-running divider keeps internal ticks evenly spaced
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			div_r <= 3'h0;
		end else begin
			div_r <= div_r + 3'h1;
		end
	end

	// ==========================================================
	// Tick selection
	always_comb begin
		mask = (3'h1 << i_prescale[1:0]) - 3'h1;
		cur = sync2_r[i_prescale[1:0]];
		old = prev_r[i_prescale[1:0]];
		if (i_edge[1]) begin
			ext_tick = cur ^ old;
		end else if (i_edge[0]) begin
			ext_tick = old & ~cur;
		end else begin
			ext_tick = cur & ~old;
		end
		if (i_prescale[2]) begin
			o_tick = ext_tick;
		end else begin
			o_tick = (div_r & mask) == mask;
		end
	end
endmodule : fct_prescaler
`default_nettype wire

// file: src/fct_axil.sv
// AXI4-Lite slave front end giving single-cycle register strobes.
// Assumes the register file answers reads combinationally by index.
`timescale 1ns/10ps
`default_nettype none
module fct_axil (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// AXI4-Lite write channels
	input wire logic [fct_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [fct_pkg::DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read channels
	input wire logic [fct_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [fct_pkg::DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// Register side
	output logic o_wr_en,
	output logic [7:0] o_wr_idx,
	output logic [15:0] o_wr_data,
	output logic [1:0] o_wr_be,
	input wire logic i_wr_hit,
	output logic [7:0] o_rd_idx,
	input wire logic [15:0] i_rd_data,
	input wire logic i_rd_hit
);
	logic aw_full_r;
	logic w_full_r;
	logic [7:0] aw_idx_r;
	logic [15:0] w_data_r;
	logic [1:0] w_be_r;

	assign o_awready = ~aw_full_r;
	assign o_wready = ~w_full_r;
	assign o_arready = ~o_rvalid;
	assign o_wr_en = aw_full_r & w_full_r & ~o_bvalid;
	assign o_wr_idx = aw_idx_r;
	assign o_wr_data = w_data_r;
	assign o_wr_be = w_be_r;
	assign o_rd_idx = i_araddr[9:2];

	// ==========================================================
	// Write address and data are taken in either order
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			aw_full_r <= 1'b0;
			aw_idx_r <= 8'h00;
		end else if (i_awvalid && !aw_full_r) begin
			aw_full_r <= 1'b1;
			aw_idx_r <= i_awaddr[9:2];
		end else if (o_wr_en) begin
			aw_full_r <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			w_full_r <= 1'b0;
			w_data_r <= 16'h0000;
			w_be_r <= 2'h0;
		end else if (i_wvalid && !w_full_r) begin
			w_full_r <= 1'b1;
			w_data_r <= i_wdata[15:0];
			w_be_r <= i_wstrb[1:0];
		end else if (o_wr_en) begin
			w_full_r <= 1'b0;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_bvalid <= 1'b0;
			o_bresp <= fct_pkg::RESP_OKAY;
		end else if (o_wr_en) begin
			o_bvalid <= 1'b1;
			o_bresp <= i_wr_hit ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
		end else if (i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// Read answered one cycle after the address is taken
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= fct_pkg::RESP_OKAY;
		end else if (i_arvalid && !o_rvalid) begin
			o_rvalid <= 1'b1;
			o_rdata <= {16'h0000, i_rd_data};
			o_rresp <= i_rd_hit ? fct_pkg::RESP_OKAY : fct_pkg::RESP_SLVERR;
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule : fct_axil
`default_nettype wire

// file: src/fct_top.sv
// Shared control of a five-channel 16-bit timer, with channel 0 counter.
// Assumes channels 1 to 4 live outside and exchange strobes on i_mclk.
//
// Decided for this implementation: the AXI4-Lite register port.
`timescale 1ns/10ps
`default_nettype none
module fct_top (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// AXI4-Lite write channels
	input wire logic [fct_pkg::ADDR_W-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [fct_pkg::DATA_W-1:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	// AXI4-Lite read channels
	input wire logic [fct_pkg::ADDR_W-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [fct_pkg::DATA_W-1:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	// External clock pins a to d
	input wire logic [3:0] i_ext_clk,
	// Other channels
	input wire logic [fct_pkg::NCH-1:1] i_ch_clear,
	input wire logic i_ch2_overflow,
	input wire logic i_ch2_underflow,
	input wire logic i_ch4_load_b,
	// Control to the channels
	output logic [fct_pkg::NCH-1:0] o_run,
	output logic [fct_pkg::NCH-1:0] o_sync,
	output logic [fct_pkg::NCH-1:0] o_pwm,
	output logic o_phase_count,
	output fct_pkg::fct_pair_t o_pair_mode,
	output logic o_ch4_buffer_en,
	output logic [fct_pkg::CNT_W-1:0] o_ch4_general_reg_b,
	// Channel 0, and the channel 2 overflow flag
	output logic [fct_pkg::CNT_W-1:0] o_channel_counter,
	output logic o_ch0_clear,
	output logic o_ch0_pwm_out,
	output logic o_overflow_flag,
	// Interrupt
	output logic o_irq
);
	localparam logic [15:0] CNT_MAX = 16'hFFFF;

	logic wr_en;
	logic [7:0] wr_idx;
	logic [15:0] wr_data;
	logic [1:0] wr_be;
	logic wr_hit;
	logic [7:0] rd_idx;
	logic [15:0] rd_data;
	logic rd_hit;
	logic tick;
	logic [7:0] run_r;
	logic [7:0] sync_r;
	logic [7:0] mode_r;
	logic [7:0] pair_r;
	logic [7:0] clk0_r;
	logic [7:0] mode_act_r;
	logic [7:0] pair_act_r;
	logic [1:0] clr_act_r;
	logic [15:0] gra_r;
	logic [15:0] grb_r;
	logic [15:0] ch4_buffer_reg_b_r;
	logic [15:0] ch4_general_reg_b_r;
	logic [15:0] cnt_r;
	logic [15:0] cnt_nxt;
	logic [fct_pkg::ST_W-1:0] stat_r;
	logic [fct_pkg::ST_W-1:0] mask_r;
	logic [fct_pkg::ST_W-1:0] ev;
	logic count_en;
	logic match_a;
	logic match_b;
	logic clr_now;

	// ==========================================================
	// Bus front end and counter clock
	fct_axil u_axil (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_awaddr(i_awaddr),
		.i_awvalid(i_awvalid),
		.o_awready(o_awready),
		.i_wdata(i_wdata),
		.i_wstrb(i_wstrb),
		.i_wvalid(i_wvalid),
		.o_wready(o_wready),
		.o_bresp(o_bresp),
		.o_bvalid(o_bvalid),
		.i_bready(i_bready),
		.i_araddr(i_araddr),
		.i_arvalid(i_arvalid),
		.o_arready(o_arready),
		.o_rdata(o_rdata),
		.o_rresp(o_rresp),
		.o_rvalid(o_rvalid),
		.i_rready(i_rready),
		.o_wr_en(wr_en),
		.o_wr_idx(wr_idx),
		.o_wr_data(wr_data),
		.o_wr_be(wr_be),
		.i_wr_hit(wr_hit),
		.o_rd_idx(rd_idx),
		.i_rd_data(rd_data),
		.i_rd_hit(rd_hit)
	);

	fct_prescaler u_psc (
		.i_mclk(i_mclk),
		.i_reset(i_reset),
		.i_ext_clk(i_ext_clk),
		.i_prescale(clk0_r[fct_pkg::PSC_LSB+:3]),
		.i_edge(clk0_r[fct_pkg::EDGE_LSB+:2]),
		.o_tick(tick)
	);

	// ==========================================================
	// Helpers
	function automatic logic [7:0] wr8(input logic [7:0] old,
		input logic [7:0] val, input logic [7:0] wmask);
		wr8 = (old & ~wmask) | (val & wmask);
	endfunction : wr8

	function automatic logic [15:0] wr16(input logic [15:0] old,
		input logic [15:0] val, input logic [1:0] be);
		wr16 = {be[1] ? val[15:8] : old[15:8], be[0] ? val[7:0] : old[7:0]};
	endfunction : wr16

	function automatic logic hit(input logic [7:0] idx);
		case (idx)
			fct_pkg::IDX_RUN, fct_pkg::IDX_SYNC, fct_pkg::IDX_MODE,
			fct_pkg::IDX_PAIR, fct_pkg::IDX_CLK0, fct_pkg::IDX_GRA0,
			fct_pkg::IDX_GRB0, fct_pkg::IDX_STAT, fct_pkg::IDX_MASK,
			fct_pkg::IDX_CNT0, fct_pkg::IDX_CH4_GENERAL_REG_B,
			fct_pkg::IDX_CH4_BUFFER_REG_B: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	endfunction : hit

	function automatic logic wsel(input logic [7:0] idx);
		wsel = wr_en && (wr_idx == idx);
	endfunction : wsel

	assign wr_hit = hit(wr_idx);
	assign rd_hit = hit(rd_idx);

	// ==========================================================
	// Control registers, reserved bits hold their reset ones
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			run_r <= fct_pkg::RST_RUN;
		end else if (wsel(fct_pkg::IDX_RUN) && wr_be[0]) begin
			run_r <= wr8(run_r, wr_data[7:0], fct_pkg::WM_RUN);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			sync_r <= fct_pkg::RST_SYNC;
		end else if (wsel(fct_pkg::IDX_SYNC) && wr_be[0]) begin
			sync_r <= wr8(sync_r, wr_data[7:0], fct_pkg::WM_RUN);
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			mode_r <= fct_pkg::RST_MODE;
			pair_r <= fct_pkg::RST_PAIR;
			clk0_r <= fct_pkg::RST_CLK0;
		end else if (wr_en && wr_be[0]) begin
			if (wr_idx == fct_pkg::IDX_MODE) begin
				mode_r <= wr8(mode_r, wr_data[7:0], fct_pkg::WM_MODE);
			end
			if (wr_idx == fct_pkg::IDX_PAIR) begin
				pair_r <= wr8(pair_r, wr_data[7:0], fct_pkg::WM_PAIR);
			end
			if (wr_idx == fct_pkg::IDX_CLK0) begin
				clk0_r <= wr8(clk0_r, wr_data[7:0], fct_pkg::WM_CLK0);
			end
		end
	end

	// Mode copies move on a counter tick so a count never sees half a change
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			mode_act_r <= fct_pkg::RST_MODE;
			pair_act_r <= fct_pkg::RST_PAIR;
			clr_act_r <= fct_pkg::CLR_NONE;
		end else if (tick) begin
			mode_act_r <= mode_r;
			pair_act_r <= pair_r;
			clr_act_r <= clk0_r[fct_pkg::CLR_LSB+:2];
		end
	end

	assign o_run = run_r[fct_pkg::NCH-1:0];
	assign o_sync = sync_r[fct_pkg::NCH-1:0];
	assign o_pwm = mode_act_r[fct_pkg::NCH-1:0];
	assign o_phase_count = mode_act_r[fct_pkg::MODE_PHASE_BIT];
	assign o_pair_mode = fct_pkg::pair_decode(
		pair_act_r[fct_pkg::PAIR_LSB+:2]);
	assign o_ch4_buffer_en = pair_act_r[fct_pkg::PAIR_BUF_BIT];

	// ==========================================================
	// Channel 0 compare registers and channel 4 register B
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			gra_r <= fct_pkg::RST_GR;
			grb_r <= fct_pkg::RST_GR;
			ch4_buffer_reg_b_r <= fct_pkg::RST_GR;
		end else if (wr_en) begin
			if (wr_idx == fct_pkg::IDX_GRA0) begin
				gra_r <= wr16(gra_r, wr_data, wr_be);
			end
			if (wr_idx == fct_pkg::IDX_GRB0) begin
				grb_r <= wr16(grb_r, wr_data, wr_be);
			end
			if (wr_idx == fct_pkg::IDX_CH4_BUFFER_REG_B) begin
				ch4_buffer_reg_b_r <= wr16(ch4_buffer_reg_b_r, wr_data, wr_be);
			end
		end
	end

	// Buffered register B takes the buffer at the channel's load strobe
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			ch4_general_reg_b_r <= fct_pkg::RST_GR;
		end else if (o_ch4_buffer_en && i_ch4_load_b) begin
			ch4_general_reg_b_r <= ch4_buffer_reg_b_r;
		end else if (wsel(fct_pkg::IDX_CH4_GENERAL_REG_B) && !o_ch4_buffer_en) begin
			ch4_general_reg_b_r <= wr16(ch4_general_reg_b_r, wr_data, wr_be);
		end
	end

	assign o_ch4_general_reg_b = ch4_general_reg_b_r;

	// ==========================================================
	// Channel 0 counter
	always_comb begin
		count_en = run_r[0] && tick;
		match_a = count_en && (cnt_r == gra_r);
		match_b = count_en && (cnt_r == grb_r);
		case (clr_act_r)
			fct_pkg::CLR_GRA: clr_now = match_a;
			fct_pkg::CLR_GRB: clr_now = match_b;
			fct_pkg::CLR_SYNC: clr_now = sync_r[0] && (|i_ch_clear);
			default: clr_now = 1'b0;
		endcase
		if (clr_now) begin
			cnt_nxt = 16'h0000;
		end else if (count_en) begin
			cnt_nxt = cnt_r + 16'h0001;
		end else begin
			cnt_nxt = cnt_r;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			cnt_r <= 16'h0000;
		end else if (wsel(fct_pkg::IDX_CNT0)) begin
			cnt_r <= wr16(cnt_r, wr_data, wr_be);
		end else begin
			cnt_r <= cnt_nxt;
		end
	end

	// Our clear is offered to synchronised partners only
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_ch0_clear <= 1'b0;
		end else begin
			o_ch0_clear <= clr_now && sync_r[0];
		end
	end

	// PWM output rises on register A match and falls on register B match
	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			o_ch0_pwm_out <= 1'b0;
		end else if (!o_pwm[0]) begin
			o_ch0_pwm_out <= 1'b0;
		end else if (match_b) begin
			o_ch0_pwm_out <= 1'b0;
		end else if (match_a) begin
			o_ch0_pwm_out <= 1'b1;
		end
	end

	assign o_channel_counter = cnt_r;

	// ==========================================================
	// Events, status and interrupt; a set beats a same-cycle clear
	always_comb begin
		ev = '0;
		ev[fct_pkg::ST_CMA] = match_a;
		ev[fct_pkg::ST_CMB] = match_b;
		ev[fct_pkg::ST_OVF0] = count_en && !clr_now && (cnt_r == CNT_MAX);
		ev[fct_pkg::ST_OVF2] = i_ch2_overflow ||
			(i_ch2_underflow && !mode_act_r[fct_pkg::MODE_FLAG_DIRECTION_BIT_BIT]);
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			stat_r <= '0;
		end else if (wsel(fct_pkg::IDX_STAT) && wr_be[0]) begin
			stat_r <= (stat_r & ~wr_data[fct_pkg::ST_W-1:0]) | ev;
		end else begin
			stat_r <= stat_r | ev;
		end
	end

	always_ff @(posedge i_mclk) begin
		if (i_reset) begin
			mask_r <= '0;
		end else if (wsel(fct_pkg::IDX_MASK) && wr_be[0]) begin
			mask_r <= wr_data[fct_pkg::ST_W-1:0];
		end
	end

	assign o_overflow_flag = stat_r[fct_pkg::ST_OVF2];
	assign o_irq = |(stat_r & mask_r);

	// ==========================================================
	// Read mux
	always_comb begin
		case (rd_idx)
			fct_pkg::IDX_RUN: rd_data = {8'h00, run_r};
			fct_pkg::IDX_SYNC: rd_data = {8'h00, sync_r};
			fct_pkg::IDX_MODE: rd_data = {8'h00, mode_r};
			fct_pkg::IDX_PAIR: rd_data = {8'h00, pair_r};
			fct_pkg::IDX_CLK0: rd_data = {8'h00, clk0_r};
			fct_pkg::IDX_GRA0: rd_data = gra_r;
			fct_pkg::IDX_GRB0: rd_data = grb_r;
			fct_pkg::IDX_STAT: rd_data = {12'h000, stat_r};
			fct_pkg::IDX_MASK: rd_data = {12'h000, mask_r};
			fct_pkg::IDX_CNT0: rd_data = cnt_r;
			fct_pkg::IDX_CH4_GENERAL_REG_B: rd_data = ch4_general_reg_b_r;
			fct_pkg::IDX_CH4_BUFFER_REG_B: rd_data = ch4_buffer_reg_b_r;
			default: rd_data = 16'h0000;
		endcase
	end
endmodule : fct_top
`default_nettype wire

// file: testbench/fct_top_assertions.sv
// Concurrent checks on the timer control block's ports.
// Assumes a single i_mclk domain and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module fct_top_assertions (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_reset,
	// Bus handshakes
	input wire logic i_bready,
	input wire logic i_rready,
	input wire logic i_awvalid,
	input wire logic o_bvalid,
	input wire logic [1:0] o_bresp,
	input wire logic o_rvalid,
	input wire logic [31:0] o_rdata,
	// Channel control
	input wire logic i_ch2_overflow,
	input wire logic [4:0] o_run,
	input wire logic [4:0] o_sync,
	input wire logic [4:0] o_pwm,
	input wire logic o_phase_count,
	input wire fct_pkg::fct_pair_t o_pair_mode,
	input wire logic [15:0] o_channel_counter,
	input wire logic o_overflow_flag,
	input wire logic o_irq
);
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_reset);
	// ==========================================================
	// Reset state
	a_run_rst: assert property ($fell(i_reset) |->
		o_run == 5'h00 && o_sync == 5'h00)
		else $error("run or sync not clear after reset");
	a_mode_rst: assert property ($fell(i_reset) |->
		o_pwm == 5'h00 && !o_phase_count &&
		o_pair_mode == fct_pkg::PAIR_NORMAL)
		else $error("mode outputs not normal after reset");
	a_cnt_rst: assert property ($fell(i_reset) |->
		o_channel_counter == 16'h0000 && !o_irq)
		else $error("counter or irq not clear after reset");
	// ==========================================================
	// Bus answers stand until taken; read data upper half is zero
	a_bv_hold: assert property (o_bvalid && !i_bready |=>
		o_bvalid && $stable(o_bresp))
		else $error("write response dropped early");
	a_rv_hold: assert property (o_rvalid && !i_rready |=>
		o_rvalid && $stable(o_rdata))
		else $error("read response dropped early");
	a_rd_upper: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
		else $error("read data upper half not zero");
	// ==========================================================
	// Channel 2 flag is set by overflow and stays until written
	a_ovf_set: assert property (i_ch2_overflow |=> o_overflow_flag)
		else $error("overflow did not set flag");
	// Sticky unless a write could have cleared it
	a_ovf_hold: assert property (o_overflow_flag && !i_awvalid &&
		!$past(i_awvalid) |=> o_overflow_flag)
		else $error("flag lost without a write");
endmodule : fct_top_assertions
bind fct_top fct_top_assertions u_chk (.*);
`default_nettype wire

// file: testbench/fct_top_bench.sv
// Self-checking bench for the five-channel timer control block.
// Assumes fct_top with its checker bound; drives all ports itself.
`timescale 1ns/10ps
`default_nettype none
module fct_top_bench;
	// ==========================================================
	// Signals
	logic i_mclk = 1'b0;
	logic i_reset = 1'b1;
	logic [11:0] i_awaddr = 12'h000, i_araddr = 12'h000;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'h3;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0;
	logic [3:0] i_ext_clk = 4'h0;
	logic [4:1] i_ch_clear = 4'h0;
	logic i_ch2_overflow = 1'b0, i_ch2_underflow = 1'b0;
	logic i_ch4_load_b = 1'b0;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata;
	logic [4:0] o_run, o_sync, o_pwm;
	logic o_phase_count, o_ch4_buffer_en, o_ch0_clear, o_ch0_pwm_out;
	logic o_overflow_flag, o_irq;
	fct_pkg::fct_pair_t o_pair_mode;
	logic [15:0] o_ch4_general_reg_b, o_channel_counter, c0, mx;
	logic [31:0] rd_v;
	logic [1:0] rs;
	int errors = 0, checked = 0;
	logic [7:0] ri [5] = '{8'h60, 8'h61, 8'h62, 8'h63, 8'h64};
	logic [7:0] rv [5] = '{8'hE0, 8'hE0, 8'h80, 8'hC7, 8'h80};

	always #20 i_mclk = ~i_mclk;
	fct_top u_dut (.*);
	// ==========================================================
	// Helpers
	task chk(input logic [31:0] s, input logic [31:0] e);
		checked++;
		if (s !== e) begin
			errors++;
			$display("[ERR] %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : stop_test
	task tk(input int n);
		repeat (n) @(posedge i_mclk);
		#1;
	endtask : tk
	// Ready is sampled at the falling edge, where it has settled
	task wr(input logic [7:0] x, input logic [15:0] d);
		logic pa, pw, ra, rw, b;
		@(posedge i_mclk);
		i_awaddr <= {2'b00, x, 2'b00};
		i_wdata <= {16'h0000, d};
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		do begin
			@(negedge i_mclk);
			ra = pa & o_awready;
			rw = pw & o_wready;
			@(posedge i_mclk);
			if (ra) i_awvalid <= 1'b0;
			if (rw) i_wvalid <= 1'b0;
			pa = pa & ~ra;
			pw = pw & ~rw;
		end while (pa | pw);
		// Late ready makes the response stand while it waits
		do begin
			@(negedge i_mclk);
			b = o_bvalid;
			@(posedge i_mclk);
		end while (b !== 1'b1);
		i_bready <= 1'b1;
		@(negedge i_mclk);
		rs = o_bresp;
		@(posedge i_mclk);
		i_bready <= 1'b0;
		#1;
	endtask : wr
	task rd(input logic [7:0] x);
		logic ra, b;
		@(posedge i_mclk);
		i_araddr <= {2'b00, x, 2'b00};
		i_arvalid <= 1'b1;
		do begin
			@(negedge i_mclk);
			ra = o_arready;
			@(posedge i_mclk);
		end while (ra !== 1'b1);
		i_arvalid <= 1'b0;
		do begin
			@(negedge i_mclk);
			b = o_rvalid;
			@(posedge i_mclk);
		end while (b !== 1'b1);
		i_rready <= 1'b1;
		@(negedge i_mclk);
		rd_v = o_rdata;
		rs = o_rresp;
		@(posedge i_mclk);
		i_rready <= 1'b0;
		#1;
	endtask : rd
	task pu(input logic u);
		@(posedge i_mclk);
		if (u) i_ch2_underflow <= 1'b1;
		else i_ch2_overflow <= 1'b1;
		@(posedge i_mclk);
		i_ch2_underflow <= 1'b0;
		i_ch2_overflow <= 1'b0;
		#1;
	endtask : pu
	// ==========================================================
	// Tests
	initial begin
		repeat (4) @(posedge i_mclk);
		i_reset <= 1'b0;
		for (int i = 0; i < 5; i++) begin
			rd(ri[i]);
			chk(rd_v, 32'(rv[i]));
		end
		rd(8'h70);
		chk(32'(rs), 32'h2);
		chk(rd_v, 32'h0);
		$display("test reset values done");
		wr(8'h60, 16'h001F);
		chk(32'(rs), 32'h0);
		chk(32'(o_run), 32'h1F);
		wr(8'h60, 16'h000A);
		rd(8'h60);
		chk(rd_v, 32'hEA);
		chk(32'(o_run), 32'h0A);
		wr(8'h61, 16'h0015);
		chk(32'(o_sync), 32'h15);
		wr(8'h62, 16'h005F);
		tk(3);
		chk(32'({o_pwm, o_phase_count}), 32'h3F);
		wr(8'h62, 16'h0000);
		tk(3);
		chk(32'({o_pwm, o_phase_count}), 32'h0);
		for (int c = 0; c < 4; c++) begin
			wr(8'h63, 16'(c << 4));
			tk(3);
			chk(32'(o_pair_mode), c > 1 ? c - 1 : 0);
		end
		$display("test modes done");
		// A write to the general register is dropped while buffered
		wr(8'h63, 16'h0008);
		tk(3);
		chk(32'(o_ch4_buffer_en), 32'h1);
		wr(8'h6E, 16'h1234);
		wr(8'h6D, 16'h5555);
		chk(32'(o_ch4_general_reg_b), 32'hFFFF);
		@(posedge i_mclk);
		i_ch4_load_b <= 1'b1;
		@(posedge i_mclk);
		i_ch4_load_b <= 1'b0;
		tk(1);
		chk(32'(o_ch4_general_reg_b), 32'h1234);
		wr(8'h63, 16'h0000);
		tk(3);
		wr(8'h6D, 16'h00AB);
		chk(32'(o_ch4_general_reg_b), 32'h00AB);
		$display("test buffer done");
		wr(8'h60, 16'h0001);
		for (int k = 0; k < 4; k++) begin
			wr(8'h64, 16'(k));
			tk(4);
			c0 = o_channel_counter;
			tk(32);
			chk(32'(o_channel_counter - c0), 32 >> k);
		end
		for (int k = 0; k < 4; k++) begin
			wr(8'h64, 16'((k << 3) | (k + 4)));
			tk(4);
			c0 = o_channel_counter;
			repeat (8) begin
				@(posedge i_mclk);
				i_ext_clk[k] <= ~i_ext_clk[k];
				tk(3);
			end
			tk(6);
			chk(32'(o_channel_counter - c0), k > 1 ? 8 : 4);
		end
		$display("test clock select done");
		wr(8'h68, 16'h0005);
		wr(8'h69, 16'h0009);
		for (int c = 0; c < 3; c++) begin
			wr(8'h64, 16'(c << 5));
			wr(8'h6C, 16'h0000);
			mx = 16'h0000;
			repeat (40) begin
				tk(1);
				if (o_channel_counter > mx) mx = o_channel_counter;
			end
			if (c == 0) chk(32'(mx > 16'd9), 32'h1);
			else chk(32'(mx), c == 1 ? 5 : 9);
		end
		// Channel 0 output is high from register A to register B match
		wr(8'h62, 16'h0001);
		tk(12);
		while (o_channel_counter != 16'h0007) tk(1);
		chk(32'(o_ch0_pwm_out), 32'h1);
		while (o_channel_counter != 16'h0001) tk(1);
		chk(32'(o_ch0_pwm_out), 32'h0);
		wr(8'h61, 16'h0001);
		wr(8'h64, 16'h0060);
		tk(8);
		@(posedge i_mclk);
		i_ch_clear <= 4'h2;
		@(posedge i_mclk);
		i_ch_clear <= 4'h0;
		#1;
		chk(32'(o_channel_counter), 32'h0);
		chk(32'(o_ch0_clear), 32'h1);
		$display("test clear done");
		wr(8'h64, 16'h0000);
		wr(8'h6A, 16'h000F);
		wr(8'h6B, 16'h0008);
		pu(1'b1);
		chk(32'({o_overflow_flag, o_irq}), 32'h3);
		wr(8'h6A, 16'h0008);
		chk(32'({o_overflow_flag, o_irq}), 32'h0);
		wr(8'h62, 16'h0020);
		tk(3);
		pu(1'b1);
		chk(32'(o_overflow_flag), 32'h0);
		pu(1'b0);
		chk(32'({o_overflow_flag, o_irq}), 32'h3);
		wr(8'h6B, 16'h0000);
		chk(32'({o_overflow_flag, o_irq}), 32'h2);
		$display("test flag done");
		stop_test();
	end
	// A hang counts as a mismatch
	initial begin
		repeat (20000) @(posedge i_mclk);
		errors++;
		stop_test();
	end
endmodule : fct_top_bench
`default_nettype wire
